// ==== include/lmc_pkg.sv ====
package lmc_pkg;
  // clock and timing (ns figures as specified, cycles derived)
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SLEEP_ENTRY_DELAY_NS = 50000;
  localparam int unsigned SLEEP_ENTRY_DELAY_CYCLES = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MODE_SETUP_NS = 5000;
  localparam int unsigned MODE_SETUP_CYCLES = (MODE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIRST_TX_DELAY_NS = 50000;
  localparam int unsigned FIRST_TX_DELAY_CYCLES = (FIRST_TX_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAST_ENTRY_WINDOW_NS = 35000;
  localparam int unsigned FAST_ENTRY_WINDOW_CYCLES = FAST_ENTRY_WINDOW_NS / CLK_PERIOD_NS;
  localparam int unsigned FAST_EXIT_GLITCH_TIME_NS = 5000;
  localparam int unsigned FAST_EXIT_GLITCH_TIME_CYCLES = FAST_EXIT_GLITCH_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TOGGLE_STEP_CYCLES = FAST_ENTRY_WINDOW_CYCLES / 4;
  localparam int unsigned GLITCH_LOW_CYCLES = FAST_EXIT_GLITCH_TIME_CYCLES / 2;
  localparam int unsigned CNT_W = 16;

  // register map
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] TXDATA_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam int unsigned CTRL_SELECT_BIT = 0;
  localparam int unsigned CTRL_SLOW_BIT = 1;
  localparam int unsigned CTRL_SLEEP_BIT = 2;
  localparam int unsigned CTRL_TOGGLE_BIT = 3;
  localparam int unsigned CTRL_GLITCH_BIT = 4;
  localparam int unsigned STATUS_RXD_BIT = 4;
  localparam int unsigned STATUS_INH_BIT = 5;
  localparam int unsigned STATUS_WAKE_BIT = 6;
  localparam int unsigned STATUS_REFUSED_BIT = 7;
  localparam int unsigned STATUS_BUSY_BIT = 8;
  localparam int unsigned STATUS_SLOW_BIT = 9;
  localparam logic TXDATA_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_AWAKE = 4'h0,
    ST_SETUP = 4'h1,
    ST_HOLD = 4'h2,
    ST_ACTIVE = 4'h3,
    ST_SLEEP_WAIT = 4'h4,
    ST_SLEEP = 4'h5,
    ST_TOG_LOW = 4'h6,
    ST_TOG_TXD = 4'h7,
    ST_FAST = 4'h8,
    ST_GLITCH = 4'h9
  } lmc_state_t;

  typedef struct packed {
    logic glitch;
    logic toggle;
    logic sleep;
    logic slow;
    logic select;
  } lmc_cmd_t;
endpackage

// ==== design/lmc_host.sv ====
// What this block does
// - sleep request: enable low with txd high, effective after a filter delay.
// - normal mode: txd high before enable rises after sleep.
// - slow mode: txd low before enable rises after sleep.
// - fast entry: both low, txd high, enable high, all within 35 us.
// - fast exit by repeated toggle or enable low glitch under 5.0 us.
// - sleep entry delay after enable falls is at least 50 us.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module lmc_host import lmc_pkg::*; #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned SLEEP_CYCLES = SLEEP_ENTRY_DELAY_CYCLES,
  parameter int unsigned FIRST_TX_CYCLES = FIRST_TX_DELAY_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // transceiver pins
  output logic o_txd,
  output logic o_en,
  input wire logic i_rxd,
  input wire logic i_inh
);
  lmc_state_t state;
  lmc_cmd_t cmd;
  logic [CNT_W-1:0] cnt;
  logic rxd_m, rxd_s, inh_m, inh_s;
  logic tx_data, slow_sel, fast_on, wake_seen, refused;
  logic aw_got, w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_take, w_take, wr_fire, b_done, ar_take, r_done, cmd_any, cmd_ok, busy, wake_clr;

  // pin synchronisers
  always_ff @(posedge i_clk) begin
    rxd_m <= i_rxd;
    rxd_s <= rxd_m;
    inh_m <= i_inh;
    inh_s <= inh_m;
  end

  // axi4-lite write channel
  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign wr_fire = aw_got && w_got && !o_bvalid;
  assign b_done = o_bvalid && i_bready;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_got <= 1'b1;
        aw_addr <= i_awaddr;
      end else if (b_done) begin
        aw_got <= 1'b0;
      end
      if (w_take) begin
        w_got <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end else if (b_done) begin
        w_got <= 1'b0;
      end
      o_awready <= !(aw_take || (aw_got && !b_done));
      o_wready <= !(w_take || (w_got && !b_done));
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp <= (aw_addr == ADDR_W'(CTRL_OFFSET) || aw_addr == ADDR_W'(TXDATA_OFFSET) ||
                  aw_addr == ADDR_W'(STATUS_OFFSET)) ? RESP_OKAY : RESP_SLVERR;
    end else if (b_done) begin
      o_bvalid <= 1'b0;
    end
  end

  // command strobes and register writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd <= '0;
    end else if (wr_fire && w_strb[0] && aw_addr == ADDR_W'(CTRL_OFFSET)) begin
      cmd.select <= w_data[CTRL_SELECT_BIT];
      cmd.slow <= w_data[CTRL_SLOW_BIT];
      cmd.sleep <= w_data[CTRL_SLEEP_BIT];
      cmd.toggle <= w_data[CTRL_TOGGLE_BIT];
      cmd.glitch <= w_data[CTRL_GLITCH_BIT];
    end else begin
      cmd <= '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_data <= TXDATA_RESET;
    end else if (wr_fire && w_strb[0] && aw_addr == ADDR_W'(TXDATA_OFFSET)) begin
      tx_data <= w_data[0];
    end
  end

  // sticky flags: a new event wins over a write-one-to-clear
  assign wake_clr = wr_fire && w_strb[0] && aw_addr == ADDR_W'(STATUS_OFFSET);
  assign cmd_any = cmd.select || cmd.sleep || cmd.toggle || cmd.glitch;
  assign busy = !(state == ST_AWAKE || state == ST_ACTIVE || state == ST_FAST || state == ST_SLEEP);
  assign cmd_ok = (cmd.select && (state == ST_AWAKE || state == ST_SLEEP)) ||
                  (cmd.sleep && (state == ST_ACTIVE || state == ST_FAST)) ||
                  (cmd.toggle && (state == ST_ACTIVE || state == ST_FAST)) ||
                  (cmd.glitch && state == ST_FAST);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_seen <= 1'b0;
    end else if (state == ST_SLEEP && !rxd_s) begin
      wake_seen <= 1'b1;
    end else if (wake_clr && w_data[STATUS_WAKE_BIT]) begin
      wake_seen <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      refused <= 1'b0;
    end else if (cmd_any && !cmd_ok) begin
      refused <= 1'b1;
    end else if (wake_clr && w_data[STATUS_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  // axi4-lite read channel
  assign ar_take = i_arvalid && o_arready;
  assign r_done = o_rvalid && i_rready;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else begin
      o_arready <= !(ar_take || (o_rvalid && !r_done));
      if (ar_take) begin
        o_rvalid <= 1'b1;
        o_rresp <= RESP_OKAY;
        o_rdata <= '0;
        if (i_araddr == ADDR_W'(TXDATA_OFFSET)) begin
          o_rdata[0] <= tx_data;
        end else if (i_araddr == ADDR_W'(STATUS_OFFSET)) begin
          o_rdata[3:0] <= state;
          o_rdata[STATUS_RXD_BIT] <= rxd_s;
          o_rdata[STATUS_INH_BIT] <= inh_s;
          o_rdata[STATUS_WAKE_BIT] <= wake_seen;
          o_rdata[STATUS_REFUSED_BIT] <= refused;
          o_rdata[STATUS_BUSY_BIT] <= busy;
          o_rdata[STATUS_SLOW_BIT] <= slow_sel;
        end else if (i_araddr != ADDR_W'(CTRL_OFFSET)) begin
          o_rresp <= RESP_SLVERR;
        end
      end else if (r_done) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // mode sequencer driving txd and enable
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_AWAKE;
      cnt <= '0;
      o_txd <= 1'b1;
      o_en <= 1'b0;
      slow_sel <= 1'b0;
      fast_on <= 1'b0;
    end else begin
      if (cnt != '0) begin
        cnt <= cnt - CNT_W'(1);
      end
      unique case (state)
        ST_AWAKE, ST_SLEEP: begin
          if (state == ST_SLEEP && !rxd_s) begin
            state <= ST_AWAKE;
          end else if (cmd.select) begin
            state <= ST_SETUP;
            slow_sel <= cmd.slow;
            o_txd <= !cmd.slow;
            cnt <= CNT_W'(MODE_SETUP_CYCLES - 1);
          end
        end
        ST_SETUP: begin
          if (cnt == '0) begin
            state <= ST_HOLD;
            o_en <= 1'b1;
            cnt <= CNT_W'(FIRST_TX_CYCLES - 1);
          end
        end
        ST_HOLD: begin
          // wait-slow transition settles before traffic
          if (cnt == '0) begin
            state <= ST_ACTIVE;
            fast_on <= 1'b0;
          end
        end
        ST_ACTIVE, ST_FAST: begin
          o_txd <= tx_data;
          if (cmd.sleep) begin
            state <= ST_SLEEP_WAIT;
            o_txd <= 1'b1;
            o_en <= 1'b0;
            cnt <= CNT_W'(SLEEP_CYCLES - 1);
          end else if (cmd.toggle) begin
            state <= ST_TOG_LOW;
            o_txd <= 1'b0;
            o_en <= 1'b0;
            cnt <= CNT_W'(TOGGLE_STEP_CYCLES - 1);
          end else if (cmd.glitch && state == ST_FAST) begin
            state <= ST_GLITCH;
            o_en <= 1'b0;
            cnt <= CNT_W'(GLITCH_LOW_CYCLES - 1);
          end
        end
        ST_SLEEP_WAIT: begin
          if (cnt == '0) begin
            state <= ST_SLEEP;
          end
        end
        ST_TOG_LOW: begin
          if (cnt == '0) begin
            state <= ST_TOG_TXD;
            o_txd <= 1'b1;
            cnt <= CNT_W'(TOGGLE_STEP_CYCLES - 1);
          end
        end
        ST_TOG_TXD: begin
          if (cnt == '0) begin
            o_en <= 1'b1;
            fast_on <= !fast_on;
            state <= fast_on ? ST_ACTIVE : ST_FAST;
          end
        end
        ST_GLITCH: begin
          if (cnt == '0) begin
            o_en <= 1'b1;
            fast_on <= 1'b0;
            state <= ST_ACTIVE;
          end
        end
        default: begin
          state <= ST_AWAKE;
          o_en <= 1'b0;
          o_txd <= 1'b1;
        end
      endcase
    end
  end

  // helper counters for the timing checks
  logic [CNT_W-1:0] wait_len, tog_len, low_len;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_len <= '0;
      tog_len <= '0;
      low_len <= '0;
    end else begin
      wait_len <= (state == ST_SLEEP_WAIT) ? wait_len + CNT_W'(1) : '0;
      tog_len <= (state == ST_TOG_LOW || state == ST_TOG_TXD) ? tog_len + CNT_W'(1) : '0;
      low_len <= (state == ST_GLITCH) ? low_len + CNT_W'(1) : '0;
    end
  end

  txd_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_ACTIVE && $past(state) == ST_ACTIVE && $past(state, 2) == ST_ACTIVE) |-> o_txd == $past(tx_data))
    else $error("txd does not follow tx data");
  sleep_pins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_SLEEP_WAIT |-> (o_txd && !o_en))
    else $error("sleep request pins wrong");
  sleep_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_SLEEP && $past(state) == ST_SLEEP_WAIT) |-> $past(wait_len) >= CNT_W'(SLEEP_CYCLES - 1))
    else $error("sleep entered too early");
  slew_setup_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_HOLD && $rose(o_en)) |-> (o_txd == !slow_sel && $past(o_txd) == !slow_sel))
    else $error("txd not set before enable rise");
  slew_lock_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state != ST_SETUP && $past(state) != ST_AWAKE && $past(state) != ST_SLEEP) |-> $stable(slow_sel))
    else $error("slew choice changed while awake");
  toggle_pins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state == ST_TOG_LOW |=> (!o_en && (state == ST_TOG_LOW ? !o_txd : o_txd)))
    else $error("toggle sequence pins wrong");
  fast_window_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_en) && $past(state) == ST_TOG_TXD |-> $past(tog_len) < CNT_W'(FAST_ENTRY_WINDOW_CYCLES))
    else $error("toggle sequence too long");
  glitch_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_en) && $past(state) == ST_GLITCH |-> $past(low_len) < CNT_W'(FAST_EXIT_GLITCH_TIME_CYCLES))
    else $error("exit glitch too long");
  wake_report_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_SLEEP && !rxd_s) |=> (state == ST_AWAKE && wake_seen))
    else $error("wake report missed");
  select_refuse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_ACTIVE && cmd.select && !cmd.sleep && !cmd.toggle) |=> (state == ST_ACTIVE && refused))
    else $error("reselect accepted while active");
endmodule // lmc_host

// ==== bench/lmc_dev_model.sv ====
`timescale 1ns/1ps
module lmc_dev_model import lmc_pkg::*; #(
  parameter int unsigned SD_CYC = SLEEP_ENTRY_DELAY_CYCLES,
  parameter int unsigned BUS_WF = 14000,
  parameter int unsigned WAKE_WF = 8000
) (
  // clock
  input wire logic i_clk,
  // controller pins and far-side stimulus
  input wire logic i_txd,
  input wire logic i_en,
  input wire logic i_bus_dom,
  input wire logic i_wake,
  // device outputs
  output logic o_rxd,
  output logic o_inh,
  output logic o_lin,
  output logic o_fast = 1'b0,
  output logic o_slow = 1'b0
);
  typedef enum logic [1:0] {M_SLEEP, M_AWAKE, M_WSLOW, M_ACT} lmc_dm_t;
  lmc_dm_t m = M_AWAKE;
  logic en_q = 1'b0;
  logic wref = 1'b0;
  logic tl = 1'b0;
  int unsigned lo_n = 0;
  int unsigned e_n = 0;
  int unsigned dom_n = 0;
  int unsigned wk_n = 0;
  // other nodes may pull the line; our driver is on only when active
  assign o_lin = !i_bus_dom && !(m == M_ACT && !i_txd);
  assign o_inh = m != M_SLEEP;
  // floating output in sleep shows the board pull-up
  assign o_rxd = (m == M_AWAKE) ? 1'b0 : (m == M_ACT) ? o_lin : 1'b1;
  always @(posedge i_clk) begin
    en_q <= i_en;
    lo_n <= (i_en || !i_txd) ? 0 : lo_n + 1;
    e_n <= i_en ? 0 : e_n + 1;
    if (en_q && !i_en) tl <= !i_txd;
    dom_n <= (m == M_SLEEP && i_bus_dom) ? dom_n + 1 : 0;
    wk_n <= (m == M_SLEEP && i_wake != wref) ? wk_n + 1 : 0;
    if ((m == M_SLEEP || m == M_AWAKE) && i_en && !en_q) begin
      m <= i_txd ? M_ACT : M_WSLOW;
      o_slow <= !i_txd;
    end else if (m == M_SLEEP && ((!i_bus_dom && dom_n > BUS_WF) || wk_n > WAKE_WF)) begin
      m <= M_AWAKE;
    end else if (m == M_WSLOW && i_txd) begin
      m <= M_ACT;
    end else if (m == M_ACT && lo_n >= SD_CYC) begin
      m <= M_SLEEP;
      wref <= i_wake;
      o_fast <= 1'b0;
    end else if (m == M_ACT && i_en && !en_q) begin
      if (tl && i_txd && e_n < FAST_ENTRY_WINDOW_CYCLES) o_fast <= !o_fast;
      else if (e_n < FAST_EXIT_GLITCH_TIME_CYCLES) o_fast <= 1'b0;
    end
  end
endmodule // lmc_dev_model

// ==== bench/tb_lmc_host.sv ====
`timescale 1ns/1ps
module tb_lmc_host import lmc_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_awvalid = 1'b0;
  logic i_wvalid = 1'b0;
  logic i_bready = 1'b0;
  logic i_arvalid = 1'b0;
  logic i_rready = 1'b0;
  logic [11:0] i_awaddr = 12'h0;
  logic [11:0] i_araddr = 12'h0;
  logic [2:0] i_awprot = 3'h0;
  logic [2:0] i_arprot = 3'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hf;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_txd, o_en, i_rxd, i_inh, lin, fast, slow;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic bus_dom = 1'b0;
  logic wake = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2.5 i_clk = ~i_clk;
  lmc_host #(.FIRST_TX_CYCLES(200)) u_dut (.i_clk, .i_rst, .i_awvalid, .o_awready, .i_awaddr, .i_awprot,
    .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
    .i_araddr, .i_arprot, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_txd, .o_en, .i_rxd, .i_inh);
  lmc_dev_model #(.BUS_WF(100), .WAKE_WF(40)) u_dev (.i_clk, .i_txd(o_txd), .i_en(o_en), .i_bus_dom(bus_dom),
    .i_wake(wake), .o_rxd(i_rxd), .o_inh(i_inh), .o_lin(lin), .o_fast(fast), .o_slow(slow));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(aw && w)) begin
      @(negedge i_clk);
      aw = aw || o_awready === 1'b1;
      w = w || o_wready === 1'b1;
      @(posedge i_clk);
      i_awvalid <= !aw;
      i_wvalid <= !w;
    end
    do @(negedge i_clk); while (o_bvalid !== 1'b1);
    chk({30'h0, o_bresp}, {30'h0, er});
    @(posedge i_clk);
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(negedge i_clk); while (o_arready !== 1'b1);
    @(posedge i_clk);
    i_arvalid <= 1'b0;
    do @(negedge i_clk); while (o_rvalid !== 1'b1);
    d = o_rdata;
    chk({30'h0, o_rresp}, {30'h0, er});
    @(posedge i_clk);
    i_rready <= 1'b0;
  endtask
  task automatic idle();
    logic [31:0] s;
    s = 32'h100;
    repeat (2) @(posedge i_clk);
    while (s[STATUS_BUSY_BIT] !== 1'b0) rd(STATUS_OFFSET, s);
  endtask
  task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] s;
    rd(STATUS_OFFSET, s);
    chk(s & mask, exp);
  endtask
  task automatic cmd(input lmc_cmd_t c);
    wr(CTRL_OFFSET, {27'h0, c});
    idle();
  endtask
  // on_bus selects the bus dominant pulse, otherwise the local wake input
  task automatic pulse(input logic on_bus, input int n);
    if (on_bus) begin
      bus_dom <= 1'b1;
    end else begin
      wake <= 1'b1;
    end
    repeat (n) @(posedge i_clk);
    if (on_bus) begin
      bus_dom <= 1'b0;
    end else begin
      wake <= 1'b0;
    end
  endtask
  task automatic t_power();
    logic [31:0] d;
    chk(32'({i_inh, i_rxd}), 32'h2);
    stat(32'h13f, 32'h020);
    rd(CTRL_OFFSET, d);
    chk(d, 32'h0);
    rd(12'h00c, d, RESP_SLVERR);
    wr(12'h010, 32'h1, RESP_SLVERR);
  endtask
  task automatic t_sel(input logic s);
    cmd({3'h0, s, 1'b1});
    stat(32'h20f, {22'h0, s, 9'h3});
    chk(32'({o_en, slow, fast}), {29'h0, 1'b1, s, 1'b0});
  endtask
  task automatic t_data();
    wr(TXDATA_OFFSET, 32'h0);
    repeat (4) @(posedge i_clk);
    chk(32'({lin, i_rxd}), 32'h0);
    stat(32'h10, 32'h0);
    wr(TXDATA_OFFSET, 32'h1);
    repeat (4) @(posedge i_clk);
    chk(32'({lin, i_rxd}), 32'h3);
    bus_dom <= 1'b1;
    repeat (4) @(posedge i_clk);
    stat(32'h10, 32'h0);
    bus_dom <= 1'b0;
  endtask
  task automatic t_refuse(input logic s);
    cmd({3'h0, !s, 1'b1});
    stat(32'h28f, {22'h0, s, 9'h83});
    chk(32'({o_en, slow}), {30'h0, 1'b1, s});
    wr(STATUS_OFFSET, 32'h80);
    cmd(5'h10);
    stat(32'h8f, 32'h83);
    wr(STATUS_OFFSET, 32'h80);
    stat(32'h80, 32'h0);
  endtask
  task automatic t_fast();
    cmd(5'h08);
    chk(32'(fast), 32'h1);
    stat(32'hf, 32'h8);
    cmd(5'h10);
    chk(32'(fast), 32'h0);
    stat(32'hf, 32'h3);
    cmd(5'h08);
    cmd(5'h08);
    chk(32'({fast, o_en}), 32'h1);
  endtask
  task automatic t_sleep();
    wr(CTRL_OFFSET, 32'h4);
    repeat (SLEEP_ENTRY_DELAY_CYCLES - 50) @(posedge i_clk);
    chk(32'(i_inh), 32'h1);
    idle();
    repeat (4) @(posedge i_clk);
    chk(32'({i_inh, i_rxd}), 32'h1);
    stat(32'hf, 32'h5);
  endtask
  task automatic t_bus_wake();
    t_sleep();
    pulse(1'b1, 50);
    repeat (8) @(posedge i_clk);
    chk(32'(i_inh), 32'h0);
    pulse(1'b1, 150);
    repeat (8) @(posedge i_clk);
    chk(32'({i_inh, i_rxd}), 32'h2);
    stat(32'h4f, 32'h40);
    wr(STATUS_OFFSET, 32'h40);
    stat(32'h40, 32'h0);
  endtask
  task automatic t_pin_wake();
    t_sleep();
    pulse(1'b0, 20);
    repeat (8) @(posedge i_clk);
    chk(32'(i_inh), 32'h0);
    wake <= 1'b1;
    repeat (60) @(posedge i_clk);
    chk(32'({i_inh, i_rxd}), 32'h2);
    stat(32'hf, 32'h0);
    wr(STATUS_OFFSET, 32'h40);
  endtask
  initial begin
    repeat (95000) @(posedge i_clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_power();
    t_sel(1'b0);
    t_data();
    t_refuse(1'b0);
    t_fast();
    t_bus_wake();
    t_sel(1'b1);
    t_refuse(1'b1);
    t_pin_wake();
    t_sel(1'b1);
    t_sleep();
    repeat (100) @(posedge i_clk);
    chk(32'(i_inh), 32'h0);
    t_sel(1'b0);
    stop_test();
  end
endmodule // tb_lmc_host
